// >>> epp_spp_printer_port_regs.sv
// Purpose: host registers of a parallel printer port and enhanced cycles
// Assumes: host strobes, address and pins are asynchronous to sys_clk
// Notes: every pin input passes a three-stage filter before use
`timescale 1ns/100ps

// Summary of operation
// - status bit 7 shows inverted busy line
// - status bit 6 shows live ack level
// - bits 5..3 show paper, select, error
// - bit 0 set on enhanced time-out
// - writing 1 clears time-out, 0 ignored
// - control latched on write, read back
// - control bits 7..6 always read 1
// - bit 5 is direction, zero in SPP
// - bit 4 enables ack rising interrupt
// - bit 3 drives select-in output
// - bit 1 drives auto line-feed output
// - address window only in enhanced mode
// - address write cycle on write strobe
// - address read cycle on read strobe
// - four data windows, enhanced mode only
// - data write cycle on write strobe
// - data read cycle on read strobe
// - direction and address/data strobes driven
// - watchdog aborts cycle after 10 us
// - idle pins follow control register
// - three-bit register select map
module epp_spp_printer_port_regs
  import epp_port_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic epp_mode,
  input wire logic ior_n,
  input wire logic iow_n,
  input wire logic [2:0] host_addr,
  input wire logic [7:0] host_data_byte_in,
  output logic [7:0] host_data_byte_out,
  output logic host_data_byte_oe,
  input wire logic [7:0] parallel_data_bus_in,
  output logic [7:0] parallel_data_bus_out,
  output logic parallel_data_bus_oe,
  input wire logic busy_in,
  input wire logic ack_n_in,
  input wire logic paper_end_in,
  input wire logic select_status_in,
  input wire logic error_n_in,
  input wire logic wait_n_in,
  output logic strobe_n,
  output logic auto_line_feed_n,
  output logic init_n,
  output logic select_in_out_n,
  output logic ack_irq
);
  logic [SYNC_W-1:0] raw_in;
  logic [SYNC_W-1:0] s1_r, s2_r, s3_r, filt_r, filt_d_r, filt_nxt;
  logic ior_f, iow_f, ack_f, wait_f;
  logic ior_lead, iow_lead, iow_trail, ack_rise;
  logic [2:0] addr_f;
  logic [7:0] hdata_f, pd_f, status_val, control_val;
  logic is_window, dir_eff, tmo_set, tmo_clr, cyc_done;
  epp_state_e state_r, state_nxt;
  logic cyc_write_r, cyc_write_nxt, cyc_addr_r, cyc_addr_nxt;
  logic [7:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
  logic [8:0] tcnt_r, tcnt_nxt;
  logic tmo_r, tmo_nxt;
  logic [5:0] ctrl_r, ctrl_nxt;
  logic [7:0] latch_r, latch_nxt;
  logic [7:0] hout_nxt, pd_out_nxt;
  logic hoe_nxt, pd_oe_nxt, stb_nxt, afd_nxt, init_nxt, slin_nxt, irq_nxt;

  assign raw_in = {wait_n_in, error_n_in, select_status_in, paper_end_in,
                   ack_n_in, busy_in, iow_n, ior_n, host_addr,
                   host_data_byte_in, parallel_data_bus_in};

  // a change is taken only once stages two and three agree
  always_comb begin
    filt_nxt = (s2_r & s3_r) | (filt_r & (s2_r ^ s3_r));
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s1_r <= SYNC_RESET;
      s2_r <= SYNC_RESET;
      s3_r <= SYNC_RESET;
      filt_r <= SYNC_RESET;
      filt_d_r <= SYNC_RESET;
    end else begin
      s1_r <= raw_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      filt_r <= filt_nxt;
      filt_d_r <= filt_r;
    end
  end

  assign ior_f = filt_r[SY_IOR];
  assign iow_f = filt_r[SY_IOW];
  assign ack_f = filt_r[SY_ACK];
  assign wait_f = filt_r[SY_WAIT];
  assign addr_f = filt_r[SY_ADDR +: 3];
  assign hdata_f = filt_r[SY_HD +: 8];
  assign pd_f = filt_r[SY_PD +: 8];
  assign ior_lead = filt_d_r[SY_IOR] & ~ior_f;
  assign iow_lead = filt_d_r[SY_IOW] & ~iow_f;
  assign iow_trail = ~filt_d_r[SY_IOW] & iow_f;
  assign ack_rise = ~filt_d_r[SY_ACK] & ack_f;

  // windows at 3..7 exist only in enhanced mode
  assign is_window = epp_mode && (addr_f >= ADDR_EPP_ADDRESS);
  assign dir_eff = epp_mode & ctrl_r[CT_DIR];
  assign cyc_done = (state_r == EPP_STROBE) && wait_f;
  assign tmo_set = (state_r != EPP_IDLE) && !cyc_done
                   && (tcnt_r == TIMEOUT_LAST);
  assign tmo_clr = iow_trail && (addr_f == ADDR_STATUS)
                   && hdata_f[ST_TMO];

  assign status_val = {~filt_r[SY_BUSY], ack_f, filt_r[SY_PE],
                       filt_r[SY_SLCT], filt_r[SY_ERR], 3'h0}
                      | STATUS_FIXED_ONES
                      | {7'h00, tmo_r};
  assign control_val = {CTRL_READ_ONES, dir_eff, ctrl_r[4:0]};

  // enhanced cycle sequencer; waits for a ready peripheral first
  always_comb begin
    state_nxt = state_r;
    cyc_write_nxt = cyc_write_r;
    cyc_addr_nxt = cyc_addr_r;
    wdata_nxt = wdata_r;
    rdata_nxt = rdata_r;
    tcnt_nxt = tcnt_r + 9'h001;
    case (state_r)
      EPP_IDLE: begin
        tcnt_nxt = 9'h000;
        if (is_window && (iow_lead || ior_lead)) begin
          state_nxt = EPP_WAIT_READY;
          cyc_write_nxt = iow_lead;
          cyc_addr_nxt = (addr_f == ADDR_EPP_ADDRESS);
          wdata_nxt = hdata_f;
        end
      end
      EPP_WAIT_READY: begin
        if (!wait_f) begin
          state_nxt = EPP_STROBE;
        end
      end
      EPP_STROBE: begin
        if (wait_f) begin
          state_nxt = EPP_IDLE;
          if (!cyc_write_r) begin
            rdata_nxt = pd_f;
          end
        end
      end
      default: begin
        state_nxt = EPP_IDLE;
      end
    endcase
    // host data may settle late; take it again as the write ends
    if (cyc_write_r && (state_r != EPP_IDLE) && iow_trail) begin
      wdata_nxt = hdata_f;
    end
    if (tmo_set) begin
      state_nxt = EPP_IDLE;
    end
  end

  // register file; the time-out set wins over a clear in the same cycle
  always_comb begin
    tmo_nxt = tmo_r;
    ctrl_nxt = ctrl_r;
    latch_nxt = latch_r;
    if (tmo_clr) begin
      tmo_nxt = 1'b0;
    end
    if (tmo_set) begin
      tmo_nxt = 1'b1;
    end
    if (iow_trail && (addr_f == ADDR_CONTROL)) begin
      ctrl_nxt = hdata_f[5:0];
    end
    if (iow_trail && (addr_f == ADDR_DATA)) begin
      latch_nxt = hdata_f;
    end
  end

  // registered host read path and pin drivers
  always_comb begin
    hoe_nxt = !ior_f;
    hout_nxt = host_data_byte_out;
    if (!ior_f) begin
      case (addr_f)
        ADDR_DATA: hout_nxt = pd_f;
        ADDR_STATUS: hout_nxt = status_val;
        ADDR_CONTROL: hout_nxt = control_val;
        default: hout_nxt = epp_mode ? rdata_r : 8'hFF;
      endcase
    end
    irq_nxt = ctrl_r[CT_IRQEN] & ack_rise;
    init_nxt = ctrl_r[CT_INIT];
    if (state_r != EPP_IDLE) begin
      stb_nxt = !cyc_write_r;
      afd_nxt = !((state_r == EPP_STROBE) && !cyc_addr_r);
      slin_nxt = !((state_r == EPP_STROBE) && cyc_addr_r);
      pd_oe_nxt = cyc_write_r;
      pd_out_nxt = cyc_write_r ? wdata_r : latch_r;
    end else begin
      stb_nxt = !ctrl_r[CT_STB];
      afd_nxt = !ctrl_r[CT_AFD];
      slin_nxt = !ctrl_r[CT_SLIN];
      pd_oe_nxt = !dir_eff;
      pd_out_nxt = latch_r;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r <= EPP_IDLE;
      cyc_write_r <= 1'b0;
      cyc_addr_r <= 1'b0;
      wdata_r <= 8'h00;
      rdata_r <= 8'h00;
      tcnt_r <= 9'h000;
      tmo_r <= 1'b0;
      ctrl_r <= CTRL_RESET;
      latch_r <= 8'h00;
      host_data_byte_out <= 8'h00;
      host_data_byte_oe <= 1'b0;
      parallel_data_bus_out <= 8'h00;
      parallel_data_bus_oe <= 1'b0;
      strobe_n <= 1'b1;
      auto_line_feed_n <= 1'b1;
      init_n <= 1'b1;
      select_in_out_n <= 1'b1;
      ack_irq <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cyc_write_r <= cyc_write_nxt;
      cyc_addr_r <= cyc_addr_nxt;
      wdata_r <= wdata_nxt;
      rdata_r <= rdata_nxt;
      tcnt_r <= tcnt_nxt;
      tmo_r <= tmo_nxt;
      ctrl_r <= ctrl_nxt;
      latch_r <= latch_nxt;
      host_data_byte_out <= hout_nxt;
      host_data_byte_oe <= hoe_nxt;
      parallel_data_bus_out <= pd_out_nxt;
      parallel_data_bus_oe <= pd_oe_nxt;
      strobe_n <= stb_nxt;
      auto_line_feed_n <= afd_nxt;
      init_n <= init_nxt;
      select_in_out_n <= slin_nxt;
      ack_irq <= irq_nxt;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_busy_bit;
    (!ior_f && addr_f == ADDR_STATUS)
      |=> host_data_byte_out[ST_BUSY] == !$past(filt_r[SY_BUSY]);
  endproperty
  a_busy_bit: assert property (p_busy_bit)
    else $error("busy status bit wrong");

  property p_ack_bit;
    (!ior_f && addr_f == ADDR_STATUS)
      |=> host_data_byte_out[ST_ACK] == $past(ack_f);
  endproperty
  a_ack_bit: assert property (p_ack_bit)
    else $error("ack status bit wrong");

  property p_fixed_bits;
    (!ior_f && addr_f == ADDR_STATUS)
      |=> host_data_byte_out[2:1] == 2'h3;
  endproperty
  a_fixed_bits: assert property (p_fixed_bits)
    else $error("status bits 2..1 not one");

  property p_ctrl_read;
    (!ior_f && addr_f == ADDR_CONTROL && !epp_mode)
      |=> host_data_byte_out[7:5] == 3'h6;
  endproperty
  a_ctrl_read: assert property (p_ctrl_read)
    else $error("control read-back high bits wrong");

  property p_timeout;
    tmo_set |=> tmo_r && state_r == EPP_IDLE;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("watchdog did not abort and flag");

  property p_tmo_clear;
    (tmo_clr && !tmo_set) |=> !tmo_r;
  endproperty
  a_tmo_clear: assert property (p_tmo_clear)
    else $error("time-out flag not cleared");

  property p_irq;
    (ctrl_r[CT_IRQEN] && ack_rise) |=> ack_irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("ack interrupt missing");

  property p_write_cycle;
    (state_r == EPP_IDLE && is_window && iow_lead)
      |=> cyc_write_r ##1 parallel_data_bus_oe && !strobe_n;
  endproperty
  a_write_cycle: assert property (p_write_cycle)
    else $error("write cycle did not drive bus");

  property p_addr_strobe;
    (state_r == EPP_STROBE && cyc_addr_r) |=> !select_in_out_n;
  endproperty
  a_addr_strobe: assert property (p_addr_strobe)
    else $error("address strobe not asserted");

  property p_idle_dir;
    (state_r == EPP_IDLE) |=> parallel_data_bus_oe == !$past(dir_eff);
  endproperty
  a_idle_dir: assert property (p_idle_dir)
    else $error("idle bus direction wrong");

  c_write_done: cover property (cyc_done && cyc_write_r);
  c_read_done: cover property (cyc_done && !cyc_write_r);
  c_timeout: cover property (tmo_set);
  c_irq: cover property (ack_irq);
endmodule

// >>> epp_port_pkg.sv
// Purpose: constants for the parallel printer port with enhanced windows
// Assumes: 40 MHz sys_clk, byte-wide host port with three address bits
// Notes: offsets are register selects on the host address lines
package epp_port_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam int EPP_TIMEOUT_NS = 10000;
  localparam int EPP_TIMEOUT_CYC = EPP_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam logic [8:0] TIMEOUT_LAST = 9'(EPP_TIMEOUT_CYC - 1);

  localparam logic [2:0] ADDR_DATA = 3'h0;
  localparam logic [2:0] ADDR_STATUS = 3'h1;
  localparam logic [2:0] ADDR_CONTROL = 3'h2;
  localparam logic [2:0] ADDR_EPP_ADDRESS = 3'h3;

  localparam int ST_BUSY = 7;
  localparam int ST_ACK = 6;
  localparam int ST_PE = 5;
  localparam int ST_SLCT = 4;
  localparam int ST_ERR = 3;
  localparam int ST_TMO = 0;
  localparam logic [7:0] STATUS_FIXED_ONES = 8'h06;

  localparam int CT_DIR = 5;
  localparam int CT_IRQEN = 4;
  localparam int CT_SLIN = 3;
  localparam int CT_INIT = 2;
  localparam int CT_AFD = 1;
  localparam int CT_STB = 0;
  localparam logic [1:0] CTRL_READ_ONES = 2'h3;
  localparam logic [5:0] CTRL_RESET = 6'h04;

  // layout of the synchronised input vector
  localparam int SY_PD = 0;
  localparam int SY_HD = 8;
  localparam int SY_ADDR = 16;
  localparam int SY_IOR = 19;
  localparam int SY_IOW = 20;
  localparam int SY_BUSY = 21;
  localparam int SY_ACK = 22;
  localparam int SY_PE = 23;
  localparam int SY_SLCT = 24;
  localparam int SY_ERR = 25;
  localparam int SY_WAIT = 26;
  localparam int SYNC_W = 27;
  localparam logic [26:0] SYNC_RESET = 27'h0580000;

  typedef enum {EPP_IDLE, EPP_WAIT_READY, EPP_STROBE} epp_state_e;
endpackage

// >>> epp_peripheral_model.sv
// Purpose: enhanced-mode peripheral on the cable side of the port
// Assumes: strobes active low, wait_n low means ready
// Notes: stall keeps wait_n low so the host watchdog must abort
`timescale 1ns/100ps
module epp_peripheral_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic write_n,
  input wire logic dstrb_n,
  input wire logic astrb_n,
  input wire logic [7:0] pd_wire,
  input wire logic stall,
  input wire logic [7:0] rd_byte,
  output logic wait_n,
  output logic [7:0] pd_out,
  output logic pd_oe,
  output logic [7:0] got_byte,
  output logic got_addr,
  output int n_got
);
  logic [1:0] dly;
  wire strb = !dstrb_n || !astrb_n;
  // read data only while a read strobe is low, released otherwise
  assign pd_oe = strb && write_n;
  assign pd_out = rd_byte;
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wait_n <= 1'b0;
      dly <= 2'h0;
      got_byte <= 8'h00;
      got_addr <= 1'b0;
      n_got <= 0;
    end else if (!strb) begin
      wait_n <= 1'b0;
      dly <= 2'h0;
    end else if (!stall && dly == 2'h3 && !wait_n) begin
      wait_n <= 1'b1;
      if (!write_n) begin
        got_byte <= pd_wire;
        got_addr <= !astrb_n;
        n_got <= n_got + 1;
      end
    end else if (dly != 2'h3) begin
      dly <= dly + 2'h1;
    end
  end
endmodule

// >>> tb_epp_spp_printer_port_regs.sv
// Purpose: self-checking bench for the printer port registers
// Assumes: write strobes held 8 cycles and read strobes over 30 so the input filter sees them
// Notes: a released cable bus shows the inverse of its last level
`timescale 1ns/100ps
module tb_epp_spp_printer_port_regs
  import epp_port_pkg::*;
;
  logic sys_clk = 1'b0, rst = 1'b1, epp_mode = 1'b1, stall = 1'b0;
  logic ior_n = 1'b1, iow_n = 1'b1, busy = 1'b0, ack_n = 1'b1;
  logic pe = 1'b0, slct = 1'b0, err_n = 1'b1;
  logic [2:0] host_addr = 3'h0;
  logic [7:0] hd_in = 8'h00, rd_byte = 8'h00, pd_last = 8'h00;
  logic [7:0] hd_out, pd_in, pd_out, m_out, m_got;
  logic pd_oe, m_oe, m_addr, wait_n, strobe_n, afd_n, init_n, slin_n;
  logic ack_irq, hd_oe;
  int m_cnt, errors = 0, n_checks = 0, irq_cnt = 0;
  always #12.5 sys_clk = ~sys_clk;
  assign pd_in = pd_oe ? pd_out : (m_oe ? m_out : ~pd_last);
  epp_spp_printer_port_regs i_epp_spp_printer_port_regs (
    .sys_clk(sys_clk), .rst(rst), .epp_mode(epp_mode), .ior_n(ior_n),
    .iow_n(iow_n), .host_addr(host_addr), .host_data_byte_in(hd_in),
    .host_data_byte_out(hd_out), .host_data_byte_oe(hd_oe),
    .parallel_data_bus_in(pd_in), .parallel_data_bus_out(pd_out),
    .parallel_data_bus_oe(pd_oe), .busy_in(busy), .ack_n_in(ack_n),
    .paper_end_in(pe), .select_status_in(slct), .error_n_in(err_n),
    .wait_n_in(wait_n), .strobe_n(strobe_n), .auto_line_feed_n(afd_n),
    .init_n(init_n), .select_in_out_n(slin_n), .ack_irq(ack_irq));
  epp_peripheral_model i_epp_peripheral_model (
    .sys_clk(sys_clk), .rst(rst), .write_n(strobe_n), .dstrb_n(afd_n),
    .astrb_n(slin_n), .pd_wire(pd_in), .stall(stall), .rd_byte(rd_byte),
    .wait_n(wait_n), .pd_out(m_out), .pd_oe(m_oe), .got_byte(m_got),
    .got_addr(m_addr), .n_got(m_cnt));
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // only a driven level is remembered, so a floating bus stays put
  always @(posedge sys_clk) begin
    if (pd_oe || m_oe) begin
      pd_last <= pd_in;
    end
    if (ack_irq === 1'b1) begin
      irq_cnt <= irq_cnt + 1;
    end
  end
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  function automatic logic [7:0] stat(input logic t);
    return {~busy, ack_n, pe, slct, err_n, 2'h3, t};
  endfunction
  task automatic host_wr(input logic [2:0] a, input logic [7:0] d);
    host_addr <= a;
    hd_in <= d;
    iow_n <= 1'b0;
    cycles(8);
    iow_n <= 1'b1;
    cycles(8);
  endtask
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic oe;
    host_addr <= a;
    ior_n <= 1'b0;
    cycles(30);
    @(negedge sys_clk);
    d = hd_out;
    oe = hd_oe;
    @(posedge sys_clk);
    ior_n <= 1'b1;
    cycles(8);
    chk_byte(d, exp);
    chk_bit(oe, 1'b1);
    chk_bit(hd_oe, 1'b0);
  endtask
  task automatic t_status();
    for (int i = 0; i < 2; i++) begin
      {busy, ack_n, pe, slct, err_n} <= i ? 5'h15 : 5'h0A;
      cycles(2);
      rd_chk(ADDR_STATUS, stat(1'b0));
    end
    {busy, ack_n, pe, slct, err_n} <= 5'h09;
  endtask
  task automatic t_control();
    host_wr(ADDR_CONTROL, 8'h3F);
    chk_byte({4'h0, strobe_n, afd_n, init_n, slin_n}, 8'h02);
    chk_bit(pd_oe, 1'b0);
    rd_chk(ADDR_CONTROL, 8'hFF);
    epp_mode <= 1'b0;
    rd_chk(ADDR_CONTROL, 8'hDF);
    host_wr(ADDR_CONTROL, 8'hC0);
    cycles(2000);
    chk_bit(init_n, 1'b0);
    rd_chk(ADDR_CONTROL, 8'hC0);
    host_wr(ADDR_CONTROL, 8'h04);
    epp_mode <= 1'b1;
    cycles(8);
    chk_bit(pd_oe, 1'b1);
  endtask
  task automatic t_spp_strobe();
    epp_mode <= 1'b0;
    host_wr(ADDR_DATA, 8'hA5);
    rd_chk(ADDR_DATA, 8'hA5);
    host_wr(ADDR_CONTROL, 8'h05);
    cycles(20);
    chk_bit(strobe_n, 1'b0);
    chk_byte(pd_out, 8'hA5);
    host_wr(ADDR_CONTROL, 8'h04);
    cycles(20);
    chk_bit(strobe_n, 1'b1);
    epp_mode <= 1'b1;
  endtask
  task automatic t_irq();
    int c0;
    c0 = irq_cnt;
    // enabled pass first, so the disabled pass must add nothing
    for (int i = 1; i >= 0; i--) begin
      host_wr(ADDR_CONTROL, i ? 8'h14 : 8'h04);
      ack_n <= 1'b0;
      cycles(10);
      ack_n <= 1'b1;
      cycles(10);
      chk_byte(8'(irq_cnt - c0), 8'h01);
    end
  endtask
  task automatic t_epp_wr();
    host_wr(ADDR_EPP_ADDRESS, 8'h5A);
    cycles(20);
    chk_byte(m_got, 8'h5A);
    chk_bit(m_addr, 1'b1);
    for (int a = 4; a < 8; a++) begin
      host_wr(3'(a), 8'(8'h30 + a));
      cycles(20);
      chk_byte(m_got, 8'(8'h30 + a));
      chk_bit(m_addr, 1'b0);
    end
  endtask
  task automatic t_epp_rd();
    for (int a = 3; a < 8; a++) begin
      rd_byte <= 8'(8'hC0 + a);
      rd_chk(3'(a), 8'(8'hC0 + a));
    end
  endtask
  task automatic t_refused();
    int c0;
    c0 = m_cnt;
    epp_mode <= 1'b0;
    host_wr(3'h5, 8'h99);
    cycles(20);
    chk_byte(8'(m_cnt - c0), 8'h00);
    rd_chk(ADDR_EPP_ADDRESS, 8'hFF);
    epp_mode <= 1'b1;
  endtask
  task automatic t_timeout();
    stall <= 1'b1;
    host_wr(3'h4, 8'h11);
    cycles(300);
    rd_chk(ADDR_STATUS, stat(1'b0));
    cycles(100);
    rd_chk(ADDR_STATUS, stat(1'b1));
    stall <= 1'b0;
    host_wr(ADDR_STATUS, 8'hFE);
    rd_chk(ADDR_STATUS, stat(1'b1));
    host_wr(ADDR_STATUS, 8'h01);
    rd_chk(ADDR_STATUS, stat(1'b0));
  endtask
  task automatic t_reset();
    host_wr(ADDR_CONTROL, 8'h3F);
    rst <= 1'b1;
    cycles(3);
    rst <= 1'b0;
    // the input filter needs four edges before the first request
    cycles(4);
    chk_byte({4'h0, strobe_n, afd_n, init_n, slin_n}, 8'h0F);
    chk_bit(ack_irq, 1'b0);
    rd_chk(ADDR_CONTROL, {CTRL_READ_ONES, CTRL_RESET});
  endtask
  initial begin
    cycles(10);
    rst <= 1'b0;
    cycles(4);
    fork
      begin
        t_status();
        t_control();
        t_spp_strobe();
        t_irq();
        t_epp_wr();
        t_epp_rd();
        t_refused();
        t_timeout();
        t_reset();
      end
      begin
        // whole run needs about 3600 cycles; ceiling leaves wide margin
        cycles(20000);
        errors++;
      end
    join_any
    wrap_up();
  end
endmodule
